// ### rtl/gpp_pin_cell.sv
// Module: drive logic of one shared port pin
`timescale 1ns/1ps
`default_nettype none
module gpp_pin_cell
    import gpp_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire gpp_mode_t    mode,
    input  wire gpp_pin_cfg_t cfg,
    output var  gpp_pin_drv_t drv
);

    gpp_pin_drv_t drv_d;
    logic         pull_req;

    // Next pin drive per operating mode
    always_comb begin
        pull_req = ~cfg.dir & cfg.pull_en;
        drv_d    = drv;
        unique case (mode)
            MODE_ACTIVE, MODE_SUBACTIVE: begin
                drv_d.pull_on = pull_req;
                if (cfg.seg_claim) begin
                    drv_d.out = cfg.seg_val;
                    drv_d.oe  = 1'b1;
                end else if (cfg.wake_sel) begin
                    drv_d.out = 1'b0;
                    drv_d.oe  = 1'b0;
                end else begin
                    drv_d.out = cfg.latch;
                    drv_d.oe  = cfg.dir;
                end
            end
            MODE_SLEEP, MODE_SUBSLEEP: begin
                drv_d = drv;
            end
            MODE_STANDBY, MODE_WATCH: begin
                drv_d.out     = 1'b1;
                drv_d.oe      = pull_req;
                drv_d.pull_on = pull_req;
            end
            default: begin
                drv_d = '0;  // Unused mode codes release the pin
            end
        endcase
    end

    // Pin drive register; reset leaves the pin floating
    always_ff @(posedge core_clk) begin
        if (rst) begin
            drv <= '0;
        end else begin
            drv <= drv_d;
        end
    end

endmodule : gpp_pin_cell
`default_nettype wire

// ### rtl/gpp_pkg.sv
// Package: constants and carriers for the port five and six GPIO block
package gpp_pkg;

    // Sizes
    localparam int PIN_W  = 8;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;

    // Register indices; the bus byte address is four times the index
    localparam logic [15:0] IDX_P5_DATA = 16'hFFD8;
    localparam logic [15:0] IDX_P5_DIR  = 16'hFFE8;
    localparam logic [15:0] IDX_P5_PULL = 16'hFFE2;
    localparam logic [15:0] IDX_P5_WAKE = 16'hFFCC;
    localparam logic [15:0] IDX_P6_DATA = 16'hFFD9;
    localparam logic [15:0] IDX_P6_DIR  = 16'hFFE9;
    localparam logic [15:0] IDX_P6_PULL = 16'hFFE3;

    // Byte addresses on the register bus
    localparam logic [ADDR_W-1:0] ADDR_P5_DATA = {IDX_P5_DATA, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_P5_DIR  = {IDX_P5_DIR, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_P5_PULL = {IDX_P5_PULL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_P5_WAKE = {IDX_P5_WAKE, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_P6_DATA = {IDX_P6_DATA, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_P6_DIR  = {IDX_P6_DIR, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_P6_PULL = {IDX_P6_PULL, 2'b00};

    // Reset value of every register and read value of write-only ones
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] WO_READ   = 8'hFF;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Segment-select field bit positions
    localparam int SGS_B3 = 3;
    localparam int SGS_B2 = 2;
    localparam int SGS_B1 = 1;
    localparam int SGS_B0 = 0;

    // Operating modes of the chip
    typedef enum logic [2:0] {
        MODE_ACTIVE    = 3'b000,
        MODE_SUBACTIVE = 3'b001,
        MODE_SLEEP     = 3'b010,
        MODE_SUBSLEEP  = 3'b011,
        MODE_STANDBY   = 3'b100,
        MODE_WATCH     = 3'b101
    } gpp_mode_t;

    // Settings that steer one pin
    typedef struct packed {
        logic dir;
        logic latch;
        logic pull_en;
        logic wake_sel;
        logic seg_claim;
        logic seg_val;
    } gpp_pin_cfg_t;

    // What one pin drives
    typedef struct packed {
        logic out;
        logic oe;
        logic pull_on;
    } gpp_pin_drv_t;

endpackage : gpp_pkg

// ### rtl/gpp_ports.sv
// Module: ports five and six with LCD segment sharing, AXI4-Lite registers
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gpp_ports
    import gpp_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire gpp_mode_t         op_mode,
    input  wire logic [3:0]        segment_select_field,
    input  wire logic [15:0]       segment_output,
    input  wire logic [PIN_W-1:0]  pin5_in,
    output logic [PIN_W-1:0]       pin5_out,
    output logic [PIN_W-1:0]       pin5_oe,
    output logic [PIN_W-1:0]       pullup5_on,
    input  wire logic [PIN_W-1:0]  pin6_in,
    output logic [PIN_W-1:0]       pin6_out,
    output logic [PIN_W-1:0]       pin6_oe,
    output logic [PIN_W-1:0]       pullup6_on,
    output logic [PIN_W-1:0]       wakeup_input
);

    localparam int ALL_W = 2 * PIN_W;

    // Software registers
    logic [PIN_W-1:0] port_five_direction_q;
    logic [PIN_W-1:0] port_five_data_latch_q;
    logic [PIN_W-1:0] port_five_pullup_enable_q;
    logic [PIN_W-1:0] port_five_wakeup_select_q;
    logic [PIN_W-1:0] port_six_direction_q;
    logic [PIN_W-1:0] port_six_data_latch_q;
    logic [PIN_W-1:0] port_six_pullup_enable_q;

    // Bus state
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [1:0]        rresp_q;
    logic [DATA_W-1:0] rdata_q;
    logic              wr_go;
    logic              wr_en;
    logic              rd_go;
    logic              wr_hit;
    logic              rd_hit;
    logic [7:0]        rd_byte;

    // Pin vectors, port five in the low half
    logic [ALL_W-1:0] all_dir;
    logic [ALL_W-1:0] all_latch;
    logic [ALL_W-1:0] all_pull;
    logic [ALL_W-1:0] all_wake;
    logic [ALL_W-1:0] all_claim;
    logic [ALL_W-1:0] all_out;
    logic [ALL_W-1:0] all_oe;
    logic [ALL_W-1:0] all_pull_on;
    logic             p5_hi_seg;
    logic             p5_lo_seg;
    logic             p6_hi_seg;
    logic             p6_lo_seg;
    logic [PIN_W-1:0] wake_q;

    // Write: address and data are taken together, one write in flight
    assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
    assign s_axi_wready  = s_axi_awready;
    assign wr_go         = s_axi_awready;
    assign wr_en         = wr_go & s_axi_wstrb[0];

    // Write address decode
    always_comb begin
        unique case (s_axi_awaddr)
            ADDR_P5_DATA, ADDR_P5_DIR, ADDR_P5_PULL, ADDR_P5_WAKE,
            ADDR_P6_DATA, ADDR_P6_DIR, ADDR_P6_PULL: wr_hit = 1'b1;
            default:                                 wr_hit = 1'b0;
        endcase
    end

    // Write response; unmapped offsets answer SLVERR
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // Port-five registers; only byte lane 0 carries data
    always_ff @(posedge core_clk) begin
        if (rst) begin
            port_five_direction_q     <= REG_RESET;
            port_five_data_latch_q    <= REG_RESET;
            port_five_pullup_enable_q <= REG_RESET;
            port_five_wakeup_select_q <= REG_RESET;
        end else if (wr_en) begin
            if (s_axi_awaddr == ADDR_P5_DIR) begin
                port_five_direction_q <= s_axi_wdata[7:0];
            end
            if (s_axi_awaddr == ADDR_P5_DATA) begin
                port_five_data_latch_q <= s_axi_wdata[7:0];
            end
            if (s_axi_awaddr == ADDR_P5_PULL) begin
                port_five_pullup_enable_q <= s_axi_wdata[7:0];
            end
            if (s_axi_awaddr == ADDR_P5_WAKE) begin
                port_five_wakeup_select_q <= s_axi_wdata[7:0];
            end
        end
    end

    // Port-six registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            port_six_direction_q     <= REG_RESET;
            port_six_data_latch_q    <= REG_RESET;
            port_six_pullup_enable_q <= REG_RESET;
        end else if (wr_en) begin
            if (s_axi_awaddr == ADDR_P6_DIR) begin
                port_six_direction_q <= s_axi_wdata[7:0];
            end
            if (s_axi_awaddr == ADDR_P6_DATA) begin
                port_six_data_latch_q <= s_axi_wdata[7:0];
            end
            if (s_axi_awaddr == ADDR_P6_PULL) begin
                port_six_pullup_enable_q <= s_axi_wdata[7:0];
            end
        end
    end

    // Read: one read in flight, answer one cycle after the address
    assign s_axi_arready = ~rvalid_q;
    assign rd_go         = s_axi_arvalid & s_axi_arready;

    // Read mux; pins are sampled live, inputs already synchronous
    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        unique case (s_axi_araddr)
            ADDR_P5_DATA: rd_byte = (port_five_direction_q & port_five_data_latch_q)
                                  | (~port_five_direction_q & pin5_in);
            ADDR_P5_DIR:  rd_byte = WO_READ;
            ADDR_P5_PULL: rd_byte = port_five_pullup_enable_q;
            ADDR_P5_WAKE: rd_byte = port_five_wakeup_select_q;
            ADDR_P6_DATA: rd_byte = (port_six_direction_q & port_six_data_latch_q)
                                  | (~port_six_direction_q & pin6_in);
            ADDR_P6_DIR:  rd_byte = WO_READ;
            ADDR_P6_PULL: rd_byte = port_six_pullup_enable_q;
            default:      rd_hit  = 1'b0;
        endcase
    end

    // Read data register; bits above the byte read as zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= '0;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_q  <= {24'h000000, rd_byte};
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp  = rresp_q;
    assign s_axi_rdata  = rdata_q;

    // segment field decode, segments claim pins
    assign p5_hi_seg = segment_select_field[SGS_B3];
    assign p5_lo_seg = segment_select_field[SGS_B3] & segment_select_field[SGS_B0];
    // port-six claims 011* or 1***, and 0111 or 1***
    assign p6_hi_seg = segment_select_field[SGS_B3]
                     | (segment_select_field[SGS_B2] & segment_select_field[SGS_B1]);
    assign p6_lo_seg = segment_select_field[SGS_B3]
                     | (segment_select_field[SGS_B2] & segment_select_field[SGS_B1]
                        & segment_select_field[SGS_B0]);
    assign all_claim = {{4{p6_hi_seg}}, {4{p6_lo_seg}}, {4{p5_hi_seg}}, {4{p5_lo_seg}}};

    // Gather settings; port six has no wakeup function
    assign all_dir   = {port_six_direction_q, port_five_direction_q};
    assign all_latch = {port_six_data_latch_q, port_five_data_latch_q};
    assign all_pull  = {port_six_pullup_enable_q, port_five_pullup_enable_q};
    assign all_wake  = {8'h00, port_five_wakeup_select_q};

    // One drive cell per pin; port-six pin n maps to segment n+8
    for (genvar g = 0; g < ALL_W; g++) begin : g_pin
        gpp_pin_cfg_t cfg;
        gpp_pin_drv_t drv;
        // settings reach every pin; in active and subactive modes a segment claim overrides latch and direction but not the pull-up
        assign cfg.dir       = all_dir[g];
        assign cfg.latch     = all_latch[g];
        assign cfg.pull_en   = all_pull[g];
        assign cfg.wake_sel  = all_wake[g];
        assign cfg.seg_claim = all_claim[g];
        assign cfg.seg_val   = segment_output[g];
        gpp_pin_cell u_cell (
            .core_clk (core_clk),
            .rst      (rst),
            .mode     (op_mode),
            .cfg      (cfg),
            .drv      (drv)
        );
        assign all_out[g]     = drv.out;
        assign all_oe[g]      = drv.oe;
        assign all_pull_on[g] = drv.pull_on;
    end

    assign pin5_out   = all_out[PIN_W-1:0];
    assign pin5_oe    = all_oe[PIN_W-1:0];
    assign pullup5_on = all_pull_on[PIN_W-1:0];
    assign pin6_out   = all_out[ALL_W-1:PIN_W];
    assign pin6_oe    = all_oe[ALL_W-1:PIN_W];
    assign pullup6_on = all_pull_on[ALL_W-1:PIN_W];

    // Wakeup levels, idle high so an unused wakeup never fires
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wake_q <= WO_READ;
        end else begin
            wake_q <= ~(port_five_wakeup_select_q & ~all_claim[PIN_W-1:0]) | pin5_in;
        end
    end

    assign wakeup_input = wake_q;

    // Checks on the register map and the pin drive

    a_p5_dir_ones: assert property (
        @(posedge core_clk) disable iff (rst)
        (rd_go && s_axi_araddr == ADDR_P5_DIR) |=> (s_axi_rvalid && s_axi_rdata == 32'h000000FF))
        else $error("port five direction did not read all ones");

    a_p6_dir_ones: assert property (
        @(posedge core_clk) disable iff (rst)
        (rd_go && s_axi_araddr == ADDR_P6_DIR) |=> (s_axi_rvalid && s_axi_rdata == 32'h000000FF))
        else $error("port six direction did not read all ones");

    a_p5_reset_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        $fell(rst) |-> (port_five_direction_q == 8'h00 && port_five_pullup_enable_q == 8'h00
                        && port_five_wakeup_select_q == 8'h00 && pullup5_on == 8'h00))
        else $error("port five registers not clear after reset");

    a_p6_reset_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        $fell(rst) |-> (port_six_direction_q == 8'h00 && port_six_data_latch_q == 8'h00))
        else $error("port six registers not clear after reset");

    a_p6_data_read: assert property (
        @(posedge core_clk) disable iff (rst)
        (rd_go && s_axi_araddr == ADDR_P6_DATA) |=> (s_axi_rdata[7:0] ==
            (($past(port_six_direction_q) & $past(port_six_data_latch_q))
             | (~$past(port_six_direction_q) & $past(pin6_in)))))
        else $error("port six data read mismatch");

    a_p5_pull_gate: assert property (
        @(posedge core_clk) disable iff (rst)
        (op_mode == MODE_ACTIVE && $stable(port_five_direction_q) && $stable(port_five_pullup_enable_q))
        |=> (pullup5_on == ($past(~port_five_direction_q) & $past(port_five_pullup_enable_q))))
        else $error("port five pull-up does not follow direction and enable");

    a_p5_seg_upper: assert property (
        @(posedge core_clk) disable iff (rst)
        (op_mode == MODE_ACTIVE && segment_select_field[SGS_B3])
        |=> (pin5_oe[7:4] == 4'hF && pin5_out[7:4] == $past(segment_output[7:4])))
        else $error("upper port five pins not driven as segments");

    a_p5_wake_float: assert property (
        @(posedge core_clk) disable iff (rst)
        (op_mode == MODE_ACTIVE && !segment_select_field[SGS_B3] && port_five_wakeup_select_q[0])
        |=> !pin5_oe[0])
        else $error("wakeup pin is driven");

    a_sleep_holds: assert property (
        @(posedge core_clk) disable iff (rst)
        (op_mode == MODE_SLEEP) [*2] |-> ($stable(pin5_out) && $stable(pin5_oe) && $stable(pin6_oe)))
        else $error("pins changed during sleep");

    a_standby_pull: assert property (
        @(posedge core_clk) disable iff (rst)
        (op_mode == MODE_STANDBY) ##1 (op_mode == MODE_STANDBY)
        |-> (pin5_oe == pullup5_on && (pin5_out & pin5_oe) == pin5_oe))
        else $error("standby pin drive wrong");

endmodule : gpp_ports
`default_nettype wire

// ### tb/gpp_pin_model.sv
// Partner: external pin wires with pull-ups and outside drivers
`timescale 1ns/1ps
`default_nettype none
module gpp_pin_model
    import gpp_pkg::*;
(
    input  wire logic [PIN_W-1:0] oe,
    input  wire logic [PIN_W-1:0] out,
    input  wire logic [PIN_W-1:0] pull_on,
    input  wire logic [PIN_W-1:0] ext,
    output logic      [PIN_W-1:0] level
);
    // Own drive wins, then pull-up; otherwise the outside driver, which the bench rerolls per case
    assign level = (oe & out) | (~oe & pull_on) | (~oe & ~pull_on & ext);
endmodule : gpp_pin_model
`default_nettype wire

// ### tb/gpp_ports_tb.sv
// Testbench: port five and six block against a bench model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("Error t=%0t got %0h exp %0h", $time, g, e); end end
module gpp_ports_tb;
    import gpp_pkg::*;
    logic              core_clk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [3:0]        wstrb, f;
    logic [1:0]        bresp, rresp;
    logic              awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    gpp_mode_t         op_mode;
    gpp_mode_t         mlist [4];
    logic [15:0]       sego;
    logic [7:0]        p5i, p5o, p5e, pu5, p6i, p6o, p6e, pu6, wk, ext5, ext6, h5, he;
    logic [7:0]        d5, l5, p5, w5, d6, l6, p6;
    int                err_total = 0;
    int                checks_done = 0;
    int                seed = 78293;

    gpp_ports dut (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .op_mode(op_mode),
        .segment_select_field(f), .segment_output(sego), .pin5_in(p5i), .pin5_out(p5o), .pin5_oe(p5e),
        .pullup5_on(pu5), .pin6_in(p6i), .pin6_out(p6o), .pin6_oe(p6e), .pullup6_on(pu6), .wakeup_input(wk));
    gpp_pin_model pm5 (.oe(p5e), .out(p5o), .pull_on(pu5), .ext(ext5), .level(p5i));
    gpp_pin_model pm6 (.oe(p6e), .out(p6o), .pull_on(pu6), .ext(ext6), .level(p6i));

    // Free-running core clock
    always #5 core_clk = ~core_clk;

    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    // Sampled at falling edges; inputs only move at rising ones, so no race
    // Selector instead of a ref argument: 0 awready, 1 bvalid, 2 arready, 3 rvalid
    task automatic wait_sig(input int sel);
        int n;
        logic s;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
            s = (sel == 0) ? awready : (sel == 1) ? bvalid : (sel == 2) ? arready : rvalid;
            if (n > 50) begin
                err_total++;
                wrap_up();
            end
        end while (s !== 1'b1);
    endtask : wait_sig

    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        wait_sig(0);
        @(posedge core_clk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        wait_sig(1);
        `CHK(bresp, er)
        @(posedge core_clk);
        bready <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [ADDR_W-1:0] a, input logic [7:0] ed, input logic [1:0] er);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        wait_sig(2);
        @(posedge core_clk);
        arvalid <= 1'b0;
        wait_sig(3);
        `CHK(rdata, {24'h000000, ed})
        `CHK(rresp, er)
        @(posedge core_clk);
        rready <= 1'b0;
    endtask : bus_rd

    // Bench model of pin sharing, then compare pins and data reads
    task automatic check_all();
        logic [7:0] s5, s6, oe5, oe6, o5, o6, u5, u6, v5, v6;
        s5 = {{4{f[3]}}, {4{f[3] & f[0]}}};
        s6 = {{4{f[3] | (f[3:1] == 3'b011)}}, {4{f[3] | (f == 4'h7)}}};
        oe5 = s5 | (~w5 & d5);
        oe6 = s6 | d6;
        o5 = (s5 & sego[7:0]) | (~s5 & l5);
        o6 = (s6 & sego[15:8]) | (~s6 & l6);
        u5 = ~d5 & p5;
        u6 = ~d6 & p6;
        v5 = (oe5 & o5) | (~oe5 & u5) | (~oe5 & ~u5 & ext5);
        v6 = (oe6 & o6) | (~oe6 & u6) | (~oe6 & ~u6 & ext6);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        `CHK(p5e, oe5)
        `CHK(p5o & oe5, o5 & oe5)
        `CHK(pu5, u5)
        `CHK(p6e, oe6)
        `CHK(p6o & oe6, o6 & oe6)
        `CHK(pu6, u6)
        `CHK(wk, ~(w5 & ~s5) | v5)
        bus_rd(ADDR_P5_DATA, (d5 & l5) | (~d5 & v5), RESP_OKAY);
        bus_rd(ADDR_P6_DATA, (d6 & l6) | (~d6 & v6), RESP_OKAY);
        bus_rd(ADDR_P5_PULL, p5, RESP_OKAY);
        bus_rd(ADDR_P5_WAKE, w5, RESP_OKAY);
        bus_rd(ADDR_P6_PULL, p6, RESP_OKAY);
    endtask : check_all

    task automatic set_all();
        bus_wr(ADDR_P5_DIR, d5, RESP_OKAY);
        bus_wr(ADDR_P5_DATA, l5, RESP_OKAY);
        bus_wr(ADDR_P5_PULL, p5, RESP_OKAY);
        bus_wr(ADDR_P5_WAKE, w5, RESP_OKAY);
        bus_wr(ADDR_P6_DIR, d6, RESP_OKAY);
        bus_wr(ADDR_P6_DATA, l6, RESP_OKAY);
        bus_wr(ADDR_P6_PULL, p6, RESP_OKAY);
    endtask : set_all

    // Main sequence
    initial begin
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'h1;
        op_mode = MODE_ACTIVE;
        mlist = '{MODE_SLEEP, MODE_SUBSLEEP, MODE_STANDBY, MODE_WATCH};
        {f, sego, ext5, ext6, d5, l5, p5, w5, d6, l6, p6} = '0;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        `CHK({p5e, pu5, p6e, pu6, wk}, 40'h00000000FF)
        bus_rd(ADDR_P5_DIR, WO_READ, RESP_OKAY);
        bus_rd(ADDR_P6_DIR, WO_READ, RESP_OKAY);
        bus_rd(ADDR_P5_WAKE, REG_RESET, RESP_OKAY);
        bus_rd(ADDR_P5_PULL, REG_RESET, RESP_OKAY);
        bus_rd(ADDR_P6_DATA, ext6, RESP_OKAY);
        bus_wr(18'h00010, 8'h5A, RESP_SLVERR);
        bus_rd(18'h00010, 8'h00, RESP_SLVERR);
        // Strobe lane 0 off: answered but nothing written
        wstrb <= 4'h0;
        bus_wr(ADDR_P5_PULL, 8'hA5, RESP_OKAY);
        wstrb <= 4'h1;
        bus_rd(ADDR_P5_PULL, REG_RESET, RESP_OKAY);
        // Every segment-select code three times, random settings, both run modes
        for (int i = 0; i < 48; i++) begin
            {d5, l5, p5, w5} = {$random(seed)};
            {d6, l6, p6} = 24'($random(seed));
            ext5 <= 8'($random(seed));
            {sego, ext6} <= 24'($random(seed));
            f <= i[3:0];
            op_mode <= i[0] ? MODE_SUBACTIVE : MODE_ACTIVE;
            set_all();
            bus_rd(ADDR_P5_DIR, WO_READ, RESP_OKAY);
            check_all();
        end
        // Low-power modes: retain first, then drive pulled-up pins high and float the rest
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk);
            op_mode <= mlist[k];
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            h5 = p5o;
            he = p5e;
            l5 = ~l5;
            bus_wr(ADDR_P5_DATA, l5, RESP_OKAY);
            sego <= ~sego;
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            if (k < 2) begin
                `CHK({p5o, p5e}, {h5, he})
            end else begin
                `CHK({p5e, p6e}, {~d5 & p5, ~d6 & p6})
                `CHK(p5o | ~p5e, 8'hFF)
            end
        end
        // Unused mode code 6 releases every pin
        op_mode <= gpp_mode_t'(3'h6);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        `CHK({p5e, p6e, pu5, pu6}, 32'h00000000)
        op_mode <= MODE_ACTIVE;
        check_all();
        wrap_up();
    end
endmodule : gpp_ports_tb
`default_nettype wire
